// ===== hdl/completion_credit_tracker.sv
/*
  Completion credit tracker: gates Non-Posted requests toward the endpoint
  core in every method but line-rate streaming, which never holds them, so
  that their completions always fit the receive buffer, and frees the space
  as completions come back.
  Assumes the core configuration outputs and the completion header fields
  come from logic on core_clk; each completion header is one pulse.
*/
// Contract
// (R01) Boundary is 64 bytes when link control bit 3 is 0, else 128.
// (R02) Without sampling that bit, a 64 byte boundary is used.
// (R03) Completions start and end on aligned boundaries except request ends.
// (R04) Header reservation equals the boundary blocks a response may occupy.
// (R05) Request-limit headers per request: ceiling of max request by boundary.
// (R06) Request limit is min of data and header pool quotients.
// (R07) Outstanding count clears at reset, moves per send and completion.
// (R08) Per-packet reservations use ceiling formulas; I/O writes reserve no data.
// (R09) Header and data pending counters clear at reset.
// (R10) Send only if both pools fit; add and keep reservations per request.
// (R11) Per-packet: free kept reservations once all completion data returned.
// (R12) Data credits per boundary block is boundary bytes over 16.
// (R13) Per-boundary data reservation is header reservation times block credits.
// (R14) Per-boundary: each crossed block frees one header and block credits.
// (R15) Crossings are ceiling of lower address offset plus length by boundary.
// (R16) A running address rollover count may replace the crossing formula.
// (R17) I/O reads may reserve one data credit, I/O writes none.
// (R18) Completion tag selects original request type to free right credits.
// (R19) Line-rate streaming skips accounting only if completions taken at rate.
// (R20) Pool totals are fixed by payload size and performance level.
// (R21) Max request from device control bits 14:12, default 128 bytes.
// (R22) Method is a static parameter; counters hold the largest data total.
`timescale 1ns/1ps

module completion_credit_tracker #(
  parameter credit_pkg::method_e METHOD = credit_pkg::per_packet_mode,
  parameter int unsigned HEADER_TOTAL = credit_pkg::HEADER_CREDIT_TOTAL_DEF,
  parameter int unsigned DATA_TOTAL = credit_pkg::DATA_CREDIT_TOTAL_DEF,
  parameter bit USE_BOUNDARY_CFG = 1'b1,
  parameter bit USE_MAX_REQ_CFG = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // core configuration outputs
  input wire logic [15:0] cfg_link_control,
  input wire logic [15:0] cfg_device_control,
  // request from user logic
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [credit_pkg::ADDR_W-1:0] req_addr_low,
  input wire logic [credit_pkg::LEN_W-1:0] req_len_bytes,
  input wire logic req_io_read,
  input wire logic req_io_write,
  input wire logic [credit_pkg::TAG_W-1:0] req_tag,
  // completion headers from the receive interface
  input wire logic cpl_start,
  input wire logic cpl_final,
  input wire logic [credit_pkg::ADDR_W-1:0] cpl_lower_addr,
  input wire logic [credit_pkg::LEN_W-1:0] cpl_len_bytes,
  input wire logic [credit_pkg::TAG_W-1:0] cpl_tag,
  // tracker state
  output logic [credit_pkg::CREDIT_W-1:0] header_credits_reserved,
  output logic [credit_pkg::CREDIT_W-1:0] data_credits_reserved,
  output logic [credit_pkg::CREDIT_W-1:0] outstanding_request_count,
  output logic [credit_pkg::CREDIT_W-1:0] outstanding_request_limit
);

  localparam int unsigned CW = credit_pkg::CREDIT_W;
  localparam logic [CW:0] HDR_TOT = (CW+1)'(HEADER_TOTAL);
  localparam logic [CW:0] DAT_TOT = (CW+1)'(DATA_TOTAL);
  localparam bit IS_LIMIT = (METHOD == credit_pkg::request_limit_mode);
  localparam bit IS_PACKET = (METHOD == credit_pkg::per_packet_mode);
  localparam bit IS_BLOCK = (METHOD == credit_pkg::per_boundary_mode);
  localparam bit IS_STREAM = (METHOD == credit_pkg::line_rate_stream_mode);

  // ceiling of span over a power of two
  function automatic logic [CW-1:0] ceil_blocks(
    input logic [credit_pkg::SPAN_W-1:0] span,
    input logic [3:0] shift
  );
    logic [credit_pkg::SPAN_W:0] rounded;
    rounded = ({1'b0, span} + ((15'h0001 << shift) - 15'h0001)) >> shift;
    return rounded[CW-1:0];
  endfunction : ceil_blocks

  // pending counter update, never below zero
  function automatic logic [CW-1:0] credit_update(
    input logic [CW-1:0] cur,
    input logic [CW-1:0] add,
    input logic [CW-1:0] sub
  );
    logic [CW:0] sum;
    sum = {1'b0, cur} + {1'b0, add};
    return (sum > {1'b0, sub}) ? CW'(sum - {1'b0, sub}) : '0;
  endfunction : credit_update

  // configuration decode
  // (R01) boundary select bit
  // (R02) default to 64 bytes
  wire boundary_sel = USE_BOUNDARY_CFG &&
                      cfg_link_control[credit_pkg::BOUNDARY_BIT];
  wire [2:0] max_req_raw = cfg_device_control[credit_pkg::MAX_REQ_MSB:
                                               credit_pkg::MAX_REQ_LSB];
  // (R21) reserved codes and unread field fall back to 128 bytes
  wire [2:0] max_req_code = (USE_MAX_REQ_CFG &&
                             max_req_raw <= credit_pkg::MAX_REQ_LAST_CODE) ?
                            max_req_raw : 3'h0;
  wire [3:0] boundary_shift = credit_pkg::BOUNDARY_BASE_SHIFT +
                              {3'h0, boundary_sel};
  // (R12) block credits are 4 or 8, kept as a shift
  wire [3:0] per_block_shift = credit_pkg::CREDITS_PER_BLOCK_SHIFT +
                               {3'h0, boundary_sel};
  wire [credit_pkg::ADDR_W-1:0] boundary_mask = boundary_sel ? 7'h7F : 7'h3F;

  // request-limit figures
  // (R05) max request over boundary, exact since both are powers of two
  wire [3:0] max_req_shift = credit_pkg::MAX_REQ_BASE_SHIFT +
                             {1'b0, max_req_code};
  wire [3:0] hdr_per_req_shift = max_req_shift - boundary_shift;
  wire [3:0] max_req_credit_shift = max_req_shift -
                                    credit_pkg::DATA_CREDIT_SHIFT;
  // (R06) smaller of the two pool quotients
  wire [CW:0] limit_by_data = DAT_TOT >> max_req_credit_shift;
  wire [CW:0] limit_by_hdr = HDR_TOT >> hdr_per_req_shift;
  wire [CW:0] limit_min = (limit_by_data < limit_by_hdr) ?
                          limit_by_data : limit_by_hdr;

  // per-request reservations
  wire req_is_io = req_io_read | req_io_write;
  // (R04) blocks the response can occupy
  wire [credit_pkg::SPAN_W-1:0] req_blk_span =
    {7'h00, req_addr_low & boundary_mask} + {1'b0, req_len_bytes};
  wire [credit_pkg::SPAN_W-1:0] req_dat_span =
    {10'h000, req_addr_low[3:0]} + {1'b0, req_len_bytes};
  wire [CW-1:0] req_hdr_mem = ceil_blocks(req_blk_span, boundary_shift);
  wire [CW-1:0] req_hdr_res = req_is_io ? credit_pkg::IO_HEADER_CREDITS :
                              req_hdr_mem;
  // (R08) sixteen byte credits in per-packet mode
  wire [CW-1:0] req_dat_pkt = ceil_blocks(req_dat_span,
                                          credit_pkg::DATA_CREDIT_SHIFT);
  // (R13) whole blocks in per-boundary mode
  wire [CW-1:0] req_dat_blk = req_hdr_mem << per_block_shift;
  // (R17) one credit per I/O read, none per I/O write
  wire [CW-1:0] req_dat_io = req_io_write ?
                             credit_pkg::IO_WRITE_DATA_CREDITS :
                             credit_pkg::IO_READ_DATA_CREDITS;
  wire [CW-1:0] req_dat_res = req_is_io ? req_dat_io :
                              (IS_BLOCK ? req_dat_blk : req_dat_pkt);

  logic [CW-1:0] hdr_ff;
  logic [CW-1:0] dat_ff;
  logic [CW-1:0] np_cnt_ff;
  logic [CW-1:0] limit_ff;
  logic cpl_v_ff;
  logic cpl_final_ff;
  logic [CW-1:0] cpl_cross_ff;
  logic [CW-1:0] st_hdr;
  logic [CW-1:0] st_dat;
  logic st_io;

  // (R10) both pools must hold the new reservation
  wire [CW:0] hdr_need = {1'b0, hdr_ff} + {1'b0, req_hdr_res};
  wire [CW:0] dat_need = {1'b0, dat_ff} + {1'b0, req_dat_res};
  wire credit_fits = (hdr_need <= HDR_TOT) && (dat_need <= DAT_TOT);
  // (R07) stay within 0 to the limit
  wire limit_fits = np_cnt_ff < limit_ff;
  // (R19) streaming issues at line rate; completions are always taken
  assign req_ready = IS_STREAM ? 1'b1 :
                     (IS_LIMIT ? limit_fits : credit_fits);
  wire req_fire = req_valid & req_ready;

  // (R16) formula, no rollover
  // (R15) crossings from lower address and length
  // (R03) aligned completions make this count exact
  wire [credit_pkg::SPAN_W-1:0] cpl_span =
    {7'h00, cpl_lower_addr & boundary_mask} + {1'b0, cpl_len_bytes};
  wire [CW-1:0] cpl_cross = ceil_blocks(cpl_span, boundary_shift);

  // (R18) look up the original request by tag
  tag_credit_store u_store (
    .core_clk(core_clk),
    .wr_en(req_fire),
    .wr_tag(req_tag),
    .wr_header(req_hdr_res),
    .wr_data(req_dat_res),
    .wr_io(req_is_io),
    .rd_tag(cpl_tag),
    .rd_header_ff(st_hdr),
    .rd_data_ff(st_dat),
    .rd_io_ff(st_io)
  );

  // release amounts, one clock after the completion header
  wire cpl_done = cpl_v_ff & cpl_final_ff;
  // (R11) whole reservation at the last completion
  wire [CW-1:0] pkt_hdr_sub = cpl_done ? st_hdr : '0;
  wire [CW-1:0] pkt_dat_sub = cpl_done ? st_dat : '0;
  // (R14) one header and a block of data per crossing
  // (R18) I/O completions free what their request kept
  wire [CW-1:0] blk_hdr_sub = !cpl_v_ff ? '0 :
                              (st_io ? st_hdr : cpl_cross_ff);
  wire [CW-1:0] blk_dat_sub = !cpl_v_ff ? '0 :
                              (st_io ? st_dat :
                               CW'(cpl_cross_ff << per_block_shift));
  wire [CW-1:0] hdr_sub = IS_BLOCK ? blk_hdr_sub :
                          (IS_PACKET ? pkt_hdr_sub : '0);
  wire [CW-1:0] dat_sub = IS_BLOCK ? blk_dat_sub :
                          (IS_PACKET ? pkt_dat_sub : '0);
  wire counting = IS_PACKET | IS_BLOCK;
  wire [CW-1:0] hdr_add = (counting && req_fire) ? req_hdr_res : '0;
  wire [CW-1:0] dat_add = (counting && req_fire) ? req_dat_res : '0;

  wire [CW-1:0] nxt_hdr_ff = credit_update(hdr_ff, hdr_add, hdr_sub);
  wire [CW-1:0] nxt_dat_ff = credit_update(dat_ff, dat_add, dat_sub);
  wire [CW-1:0] np_add = (IS_LIMIT && req_fire) ? 10'h001 : 10'h000;
  wire [CW-1:0] np_sub = (IS_LIMIT && cpl_done) ? 10'h001 : 10'h000;
  wire [CW-1:0] nxt_np_cnt_ff = credit_update(np_cnt_ff, np_add, np_sub);

  // (R09) pending counters clear at reset
  // (R22) counters sized for the largest data pool
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hdr_ff <= credit_pkg::CREDIT_RESET;
      dat_ff <= credit_pkg::CREDIT_RESET;
    end else begin
      hdr_ff <= nxt_hdr_ff;
      dat_ff <= nxt_dat_ff;
    end
  end

  // (R07) outstanding count clears at reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      np_cnt_ff <= credit_pkg::CREDIT_RESET;
      limit_ff <= credit_pkg::CREDIT_RESET;
    end else begin
      np_cnt_ff <= nxt_np_cnt_ff;
      limit_ff <= limit_min[CW-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpl_v_ff <= 1'b0;
      cpl_final_ff <= 1'b0;
      cpl_cross_ff <= credit_pkg::CREDIT_RESET;
    end else begin
      cpl_v_ff <= cpl_start;
      cpl_final_ff <= cpl_start & cpl_final;
      cpl_cross_ff <= cpl_cross;
    end
  end

  assign header_credits_reserved = hdr_ff;
  assign data_credits_reserved = dat_ff;
  assign outstanding_request_count = np_cnt_ff;
  assign outstanding_request_limit = limit_ff;

  // checks on the tracker's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_hdr_within_total: assert property ( // (R10)
    {1'b0, hdr_ff} <= HDR_TOT)
    else $error("header credits above total");

  a_data_within_total: assert property ( // (R10)
    {1'b0, dat_ff} <= DAT_TOT)
    else $error("data credits above total");

  a_count_within_limit: assert property ( // (R07)
    IS_LIMIT && limit_ff == $past(limit_ff) |-> np_cnt_ff <= limit_ff)
    else $error("outstanding count above limit");

  a_reset_clears_counts: assert property ( // (R09)
    $past(!rst_n) |-> hdr_ff == '0 && dat_ff == '0 && np_cnt_ff == '0)
    else $error("counters not clear after reset");

  a_send_adds_reservation: assert property ( // (R10)
    counting && req_fire && hdr_sub == '0 |=>
      hdr_ff == $past(hdr_ff) + $past(req_hdr_res))
    else $error("send did not add header reservation");

  a_final_frees_packet: assert property ( // (R11)
    IS_PACKET && cpl_start && cpl_final && !req_fire
      ##1 !req_fire |=> hdr_ff == $past(hdr_ff) - $past(st_hdr))
    else $error("last completion did not free header credits");

  a_block_frees_crossings: assert property ( // (R14)
    IS_BLOCK && cpl_v_ff && !st_io && !req_fire &&
      {1'b0, hdr_ff} >= {1'b0, cpl_cross_ff} |=>
      hdr_ff == $past(hdr_ff) - $past(cpl_cross_ff))
    else $error("crossings not freed from header credits");

  a_io_write_no_data: assert property ( // (R08)
    req_io_write && !IS_LIMIT |-> req_dat_res == '0)
    else $error("I/O write reserved data credits");

  a_boundary_default: assert property ( // (R02)
    (!USE_BOUNDARY_CFG || !cfg_link_control[credit_pkg::BOUNDARY_BIT]) |->
      boundary_shift == credit_pkg::BOUNDARY_BASE_SHIFT &&
      boundary_mask == 7'h3F)
    else $error("boundary not 64 bytes when unread");

  a_limit_is_min: assert property ( // (R06)
    ##1 limit_ff <= $past(limit_by_data[CW-1:0]) &&
      limit_ff <= $past(limit_by_hdr[CW-1:0]))
    else $error("request limit above a pool quotient");

  a_stream_always_ready: assert property ( // (R19)
    IS_STREAM |-> req_ready && hdr_ff == '0)
    else $error("stream mode stalled or counted");

  c_request_sent: cover property (req_fire);
  c_request_refused: cover property (req_valid && !req_ready);
  c_multi_crossing: cover property (cpl_start && cpl_cross > 10'h001);
  c_release_and_send: cover property (req_fire && cpl_done);

endmodule : completion_credit_tracker

// ===== hdl/credit_pkg.sv
/*
  Constants and types for the completion credit tracker: credit sizes,
  configuration field positions, reset values and the method selection.
  Assumes nothing of its surroundings; every user names items in full.
*/
package credit_pkg;

  // static choice of completion space management method
  typedef enum logic [1:0] {
    request_limit_mode = 2'h0,
    per_packet_mode = 2'h1,
    per_boundary_mode = 2'h2,
    line_rate_stream_mode = 2'h3
  } method_e;

  // credit pool totals for the default core configuration
  localparam int unsigned HEADER_CREDIT_TOTAL_DEF = 36;
  localparam int unsigned DATA_CREDIT_TOTAL_DEF = 77;

  // widths
  localparam int unsigned CREDIT_W = 10;
  localparam int unsigned TAG_W = 5;
  localparam int unsigned LEN_W = 13;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned SPAN_W = 14;

  // configuration field positions
  localparam int unsigned BOUNDARY_BIT = 3;
  localparam int unsigned MAX_REQ_LSB = 12;
  localparam int unsigned MAX_REQ_MSB = 14;
  localparam logic [2:0] MAX_REQ_LAST_CODE = 3'h5;

  // log2 of byte sizes: 16 byte data credit, 64 byte boundary, 128 byte
  // smallest read request
  localparam logic [3:0] DATA_CREDIT_SHIFT = 4'h4;
  localparam logic [3:0] BOUNDARY_BASE_SHIFT = 4'h6;
  localparam logic [3:0] MAX_REQ_BASE_SHIFT = 4'h7;
  // log2 of data credits per 64 byte boundary block
  localparam logic [3:0] CREDITS_PER_BLOCK_SHIFT = 4'h2;

  // fixed reservations for I/O requests
  localparam logic [CREDIT_W-1:0] IO_HEADER_CREDITS = 10'h001;
  localparam logic [CREDIT_W-1:0] IO_READ_DATA_CREDITS = 10'h001;
  localparam logic [CREDIT_W-1:0] IO_WRITE_DATA_CREDITS = 10'h000;

  // reset values
  localparam logic [CREDIT_W-1:0] CREDIT_RESET = 10'h000;

endpackage : credit_pkg

// ===== hdl/tag_credit_store.sv
/*
  Per-tag store of the credits reserved for each outstanding request and
  whether the request was an I/O transaction.
  Assumes one write and one read per cycle on the same clock; read data
  appear one clock after the address, from a register.
*/
`timescale 1ns/1ps

module tag_credit_store (
  // clock
  input wire logic core_clk,
  // write side
  input wire logic wr_en,
  input wire logic [credit_pkg::TAG_W-1:0] wr_tag,
  input wire logic [credit_pkg::CREDIT_W-1:0] wr_header,
  input wire logic [credit_pkg::CREDIT_W-1:0] wr_data,
  input wire logic wr_io,
  // read side
  input wire logic [credit_pkg::TAG_W-1:0] rd_tag,
  output logic [credit_pkg::CREDIT_W-1:0] rd_header_ff,
  output logic [credit_pkg::CREDIT_W-1:0] rd_data_ff,
  output logic rd_io_ff
);

  localparam int unsigned DEPTH = 1 << credit_pkg::TAG_W;

  logic [credit_pkg::CREDIT_W-1:0] header_mem [DEPTH];
  logic [credit_pkg::CREDIT_W-1:0] data_mem [DEPTH];
  logic io_mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      header_mem[wr_tag] <= wr_header;
      data_mem[wr_tag] <= wr_data;
      io_mem[wr_tag] <= wr_io;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_header_ff <= header_mem[rd_tag];
    rd_data_ff <= data_mem[rd_tag];
    rd_io_ff <= io_mem[rd_tag];
  end

endmodule : tag_credit_store

// ===== testbench/completion_credit_tracker_tb.sv
/*
  Self-checking bench for the tracker in per-packet mode.
  Assumes the core_side_model stand-in and the credit package.
*/
`timescale 1ns/1ps

module completion_credit_tracker_tb;
  // pool totals of the default configuration
  localparam int HT = 36;
  localparam int DT = 77;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic boundary_128 = 1'b0;
  logic hold_cpl = 1'b0;
  logic [2:0] max_req_code = 3'h0;
  logic req_valid = 1'b0;
  logic req_io_read = 1'b0;
  logic req_io_write = 1'b0;
  logic [credit_pkg::ADDR_W-1:0] req_addr_low = 7'h00;
  logic [credit_pkg::LEN_W-1:0] req_len_bytes = 13'h0001;
  logic [credit_pkg::TAG_W-1:0] req_tag = 5'h00;
  logic req_ready, cpl_start, cpl_final;
  logic [15:0] cfg_link_control, cfg_device_control;
  logic [credit_pkg::ADDR_W-1:0] cpl_lower_addr;
  logic [credit_pkg::LEN_W-1:0] cpl_len_bytes;
  logic [credit_pkg::TAG_W-1:0] cpl_tag;
  logic [credit_pkg::CREDIT_W-1:0] hdr_res, dat_res, out_cnt, out_lim;
  int mismatches = 0;
  int samples_checked = 0;
  int exp_h, exp_d, rel_h, rel_d, nh, nd;
  int tag_h[32], tag_d[32];
  bit busy[32];

  always #10 core_clk = ~core_clk;

  completion_credit_tracker #(.METHOD(credit_pkg::per_packet_mode),
    .HEADER_TOTAL(HT), .DATA_TOTAL(DT)) DUT (
    .core_clk(core_clk), .rst_n(rst_n),
    .cfg_link_control(cfg_link_control),
    .cfg_device_control(cfg_device_control),
    .req_valid(req_valid), .req_ready(req_ready),
    .req_addr_low(req_addr_low), .req_len_bytes(req_len_bytes),
    .req_io_read(req_io_read), .req_io_write(req_io_write),
    .req_tag(req_tag), .cpl_start(cpl_start), .cpl_final(cpl_final),
    .cpl_lower_addr(cpl_lower_addr), .cpl_len_bytes(cpl_len_bytes),
    .cpl_tag(cpl_tag), .header_credits_reserved(hdr_res),
    .data_credits_reserved(dat_res), .outstanding_request_count(out_cnt),
    .outstanding_request_limit(out_lim));

  core_side_model far_end (
    .core_clk(core_clk), .rst_n(rst_n), .boundary_128(boundary_128),
    .hold_cpl(hold_cpl), .max_req_code(max_req_code),
    .req_fire(req_valid && req_ready),
    .req_tag(req_tag), .req_addr_low(req_addr_low),
    .req_len_bytes(req_len_bytes), .cfg_link_control(cfg_link_control),
    .cfg_device_control(cfg_device_control), .cpl_start(cpl_start),
    .cpl_final(cpl_final), .cpl_lower_addr(cpl_lower_addr),
    .cpl_len_bytes(cpl_len_bytes), .cpl_tag(cpl_tag));

  function automatic int need_h(int a, int l, bit io, bit b128);
    int r;
    r = b128 ? 128 : 64;
    return io ? 1 : ((a % r) + l + r - 1) / r;
  endfunction : need_h

  function automatic int need_d(int a, int l, bit ior, bit iow);
    if (ior) return 1;
    if (iow) return 0;
    return ((a % 16) + l + 15) / 16;
  endfunction : need_d

  // limit from totals, request size and boundary
  function automatic int exp_limit(bit b128, int code);
    int mrs;
    int by_h;
    mrs = (code > 5) ? 128 : 128 << code;
    by_h = HT / (mrs / (b128 ? 128 : 64));
    return (DT / (mrs / 16) < by_h) ? DT / (mrs / 16) : by_h;
  endfunction : exp_limit

  function automatic int pick_tag();
    int s;
    s = $urandom_range(0, 31);
    for (int i = 0; i < 32; i++) begin
      if (!busy[(s + i) % 32]) return (s + i) % 32;
    end
    return -1;
  endfunction : pick_tag

  task automatic check(input logic [15:0] seen, input logic [15:0] want,
                       input string what);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %0h want %0h", $time, what,
               seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // scoreboard: adds show one cycle on, releases two cycles on
  always @(negedge core_clk) begin
    nh = need_h(int'(req_addr_low), int'(req_len_bytes),
                req_io_read | req_io_write, boundary_128);
    nd = need_d(int'(req_addr_low), int'(req_len_bytes), req_io_read,
                req_io_write);
    if (!rst_n) begin
      exp_h = 0;
      exp_d = 0;
      rel_h = 0;
      rel_d = 0;
      foreach (busy[i]) busy[i] = 1'b0;
    end else begin
      check(16'(hdr_res), 16'(exp_h), "header pending");
      check(16'(dat_res), 16'(exp_d), "data pending");
      if (req_valid) check(16'(req_ready),
        16'(exp_h + nh <= HT && exp_d + nd <= DT), "ready");
      exp_h -= rel_h;
      exp_d -= rel_d;
      rel_h = 0;
      rel_d = 0;
      if (req_valid && req_ready) begin
        exp_h += nh;
        exp_d += nd;
        tag_h[req_tag] = nh;
        tag_d[req_tag] = nd;
        busy[req_tag] = 1'b1;
      end
      if (cpl_start && cpl_final) begin
        rel_h = tag_h[cpl_tag];
        rel_d = tag_d[cpl_tag];
        busy[cpl_tag] = 1'b0;
      end
    end
  end

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    req_valid <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    check(16'(hdr_res), 16'h0000, "header after reset");
    check(16'(dat_res), 16'h0000, "data after reset");
    check(16'(out_cnt), 16'h0000, "count after reset");
    @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic send_one(input logic [6:0] a, input logic [12:0] l,
                          input logic ior, input logic iow, input int tries);
    int t;
    t = pick_tag();
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_tag <= 5'(t);
    req_addr_low <= a;
    req_len_bytes <= l;
    req_io_read <= ior;
    req_io_write <= iow;
    repeat (tries) begin
      @(posedge core_clk);
      if (req_ready) break;
    end
    req_valid <= 1'b0;
  endtask : send_one

  task automatic traffic(input int cycles, input int pct);
    int t;
    int k;
    repeat (cycles) begin
      @(posedge core_clk);
      if (!req_valid || req_ready) begin
        t = pick_tag();
        k = $urandom_range(0, 7);
        req_valid <= t >= 0 && $urandom_range(0, 99) < pct;
        req_tag <= 5'(t);
        req_addr_low <= 7'($urandom);
        req_len_bytes <= 13'($urandom_range(1, 300));
        req_io_read <= k == 0;
        req_io_write <= k == 1;
      end
    end
  endtask : traffic

  task automatic drain(input string name);
    int lim;
    hold_cpl <= 1'b0;
    repeat (600) begin
      @(posedge core_clk);
      if (req_ready) req_valid <= 1'b0;
    end
    @(negedge core_clk);
    check(16'(hdr_res), 16'h0000, "header drained");
    check(16'(dat_res), 16'h0000, "data drained");
    lim = exp_limit(boundary_128, int'(max_req_code));
    check(16'(out_lim), 16'(lim), "limit");
    check(16'(out_cnt), 16'h0000, "count idle");
    @(posedge core_clk);
    $display("test %s done", name);
  endtask : drain

  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    void'($urandom(99));
    do_reset();
    hold_cpl <= 1'b1;
    send_one(7'h7C, 13'h0008, 1'b0, 1'b0, 4);
    send_one(7'h00, 13'h0040, 1'b0, 1'b0, 4);
    send_one(7'h3F, 13'h0041, 1'b0, 1'b0, 4);
    send_one(7'h10, 13'h0004, 1'b1, 1'b0, 4);
    send_one(7'h10, 13'h0004, 1'b0, 1'b1, 4);
    send_one(7'h00, 13'h1000, 1'b0, 1'b0, 6);
    drain("corner requests");
    hold_cpl <= 1'b1;
    traffic(150, 90);
    hold_cpl <= 1'b0;
    traffic(300, 60);
    drain("boundary 64 traffic");
    boundary_128 <= 1'b1;
    repeat (4) @(posedge core_clk);
    send_one(7'h40, 13'h0081, 1'b0, 1'b0, 4);
    hold_cpl <= 1'b1;
    traffic(150, 90);
    hold_cpl <= 1'b0;
    traffic(300, 60);
    drain("boundary 128 traffic");
    hold_cpl <= 1'b1;
    traffic(100, 90);
    do_reset();
    traffic(200, 50);
    drain("reset in mid-run");
    max_req_code <= 3'h2;
    drain("request size 512");
    max_req_code <= 3'h7;
    drain("reserved size code");
    final_report();
  end
endmodule : completion_credit_tracker_tb

// ===== testbench/core_side_model.sv
/*
  Stand-in for the endpoint core: drives the configuration outputs and
  returns completions for each request that the tracker lets through.
  Assumes req_fire is the tracker's request handshake on core_clk.
*/
`timescale 1ns/1ps

module core_side_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench controls
  input wire logic boundary_128,
  input wire logic hold_cpl,
  input wire logic [2:0] max_req_code,
  // accepted requests
  input wire logic req_fire,
  input wire logic [credit_pkg::TAG_W-1:0] req_tag,
  input wire logic [credit_pkg::ADDR_W-1:0] req_addr_low,
  input wire logic [credit_pkg::LEN_W-1:0] req_len_bytes,
  // configuration and completion header
  output logic [15:0] cfg_link_control,
  output logic [15:0] cfg_device_control,
  output logic cpl_start,
  output logic cpl_final,
  output logic [credit_pkg::ADDR_W-1:0] cpl_lower_addr,
  output logic [credit_pkg::LEN_W-1:0] cpl_len_bytes,
  output logic [credit_pkg::TAG_W-1:0] cpl_tag
);
  int pend_q[$];
  int addr_a[32];
  int left_a[32];
  int t;
  int n;
  int rcb;

  initial begin
    cpl_start = 1'b0;
    cpl_final = 1'b0;
    cpl_lower_addr = 7'h00;
    cpl_len_bytes = 13'h0000;
    cpl_tag = 5'h00;
  end

  always @(posedge core_clk) begin
    cfg_link_control <= {12'h000, boundary_128, 3'h0};
    cfg_device_control <= {1'b0, max_req_code, 12'h000};
    // idle header fields change every cycle
    cpl_start <= 1'b0;
    cpl_final <= ~cpl_final;
    cpl_tag <= ~cpl_tag;
    cpl_lower_addr <= ~cpl_lower_addr;
    cpl_len_bytes <= ~cpl_len_bytes;
    if (!rst_n) begin
      pend_q.delete();
    end else begin
      if (req_fire) begin
        pend_q.push_back(int'(req_tag));
        addr_a[req_tag] = int'(req_addr_low);
        left_a[req_tag] = int'(req_len_bytes);
      end
      if (!hold_cpl && pend_q.size() > 0 && $urandom_range(0, 2) == 0) begin
        t = pend_q[0];
        rcb = boundary_128 ? 128 : 64;
        // split only at an aligned boundary
        n = rcb - (addr_a[t] % rcb);
        if (n >= left_a[t] || $urandom_range(0, 1) == 0) begin
          n = left_a[t];
        end
        cpl_start <= 1'b1;
        cpl_final <= n == left_a[t];
        cpl_tag <= 5'(t);
        cpl_lower_addr <= 7'(addr_a[t]);
        cpl_len_bytes <= 13'(n);
        if (n == left_a[t]) begin
          void'(pend_q.pop_front());
        end
        addr_a[t] += n;
        left_a[t] -= n;
      end
    end
  end
endmodule : core_side_model
